// >>> rtl/pbm_defines.vh
// Constants for the management register bank of the 10/100 transceiver.
`ifndef PBM_DEFINES_VH
`define PBM_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define PBM_ADDR_CONTROL 5'h00
`define PBM_ADDR_STATUS 5'h01
`define PBM_ADDR_ID_HIGH 5'h02
`define PBM_ADDR_ID_LOW 5'h03
`define PBM_ADDR_ADVERTISE 5'h04
`define PBM_ADDR_PARTNER 5'h05
`define PBM_ADDR_EXPANSION 5'h06

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PBM_RST_CONTROL 16'h3100
`define PBM_RST_STATUS 16'h7849
`define PBM_RST_ADVERTISE 16'h01e1
`define PBM_RST_PARTNER 16'h0080
`define PBM_RST_EXPANSION 16'h0000

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define PBM_CTL_SOFT_RESET 15
`define PBM_CTL_LOOPBACK 14
`define PBM_CTL_SPEED 13
`define PBM_CTL_ANEG_EN 12
`define PBM_CTL_POWER_DOWN 11
`define PBM_CTL_ANEG_RESTART 9
`define PBM_CTL_DUPLEX 8

// ----------------------------------------------------------------------
// Management frame codes
// ----------------------------------------------------------------------
`define PBM_OP_READ 2'h2
`define PBM_OP_WRITE 2'h1
`define PBM_PREAMBLE_BITS 32

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PBM_CLK_PERIOD_NS 4
`define PBM_SRST_TIME_NS 1000
`define PBM_SRST_CYCLES \
   ((`PBM_SRST_TIME_NS + `PBM_CLK_PERIOD_NS - 1) / `PBM_CLK_PERIOD_NS)

`endif

// >>> rtl/pbm_sync.v
// Two flip-flop synchroniser for a group of asynchronous levels.
module pbm_sync #(
   parameter W = 1
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   // The first stage feeds only the second stage.
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule // pbm_sync

// >>> rtl/pbm_regs.v
// Management register bank with serial management frame slave.
//
// Overview of operation
// [R1] Writing one to bit 15 restores all defaults.
// [R2] Soft reset bit clears itself when done.
// [R3] Control writes ignored during one microsecond reset.
// [R4] Zero write ignored; soft reset reads zero.
// [R5] Loopback bit routes transmit nibble to receive.
// [R6] Loopback ends on zero write or reset.
// [R7] Forced speed: one 100, zero 10.
// [R8] Speed bit idle under negotiation; reads stored.
// [R9] Fibre mode holds speed one, read-only.
// [R10] Negotiation enable overrides speed and duplex bits.
// [R11] Strap-disabled negotiation ignores enable bit writes.
// [R12] Negotiation re-enabled by one write or reset.
// [R13] Enable bit reads last written, else one; fibre mode reads zero.
// [R14] Power down stops transceiver, keeps management.
// [R15] Zero write leaves power down; reads state.
// [R16] Reset loads the documented register defaults.
// [R17] Two fixed identifier registers at two, three.
// [R18] Reset values: reset 0, enable 1, power 0.
// [R19] Management clock crosses domains through synchronisers.
// [R20] Duplex: forced when negotiation off, else result.
// [R21] Clause-22 frames, five-bit address, sixteen-bit data.
`include "pbm_defines.vh"
module pbm_regs #(
   parameter [15:0] ID_HIGH = 16'h0a5a, // Arbitrary identification value.
   parameter [15:0] ID_LOW = 16'h5a0a // Arbitrary identification value.
) (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire mdc_i,
   input wire mdio_i,
   output reg mdio_o,
   output reg mdio_oe_n_o,
   input wire [4:0] phy_addr_i,
   input wire negotiation_strap_pin_i,
   input wire fibre_fast_mode_i,
   input wire aneg_speed_100_i,
   input wire aneg_full_duplex_i,
   input wire [3:0] txd_i,
   input wire tx_en_i,
   input wire [3:0] line_rxd_i,
   input wire line_rx_dv_i,
   output reg [3:0] rxd_o,
   output reg rx_dv_o,
   output reg loopback_o,
   output reg speed_100_o,
   output reg full_duplex_o,
   output reg aneg_enable_o,
   output reg aneg_restart_o,
   output reg power_down_o,
   output reg soft_reset_o
);

   // -------------------------------------------------------------------
   // Frame states and constants
   // -------------------------------------------------------------------
   localparam [2:0] S_PRE = 3'h0;
   localparam [2:0] S_ST = 3'h1;
   localparam [2:0] S_HDR = 3'h2;
   localparam [2:0] S_TA = 3'h3;
   localparam [2:0] S_DATA = 3'h4;
   localparam [15:0] CTL_DEF = `PBM_RST_CONTROL;
   localparam integer SRST_INT = `PBM_SRST_CYCLES;
   localparam integer PRE_INT = `PBM_PREAMBLE_BITS;
   localparam [7:0] SRST_CYCLES = SRST_INT[7:0];
   localparam [5:0] PRE_BITS = PRE_INT[5:0];

   // -------------------------------------------------------------------
   // Reset release and input synchronisers
   // -------------------------------------------------------------------
   reg [1:0] rst_pipe_reg;
   wire rst_n;
   wire [10:0] sync_in;
   wire [10:0] sync_out;
   wire mdc_s;
   wire mdio_s;
   wire [4:0] phy_addr_s;
   wire strap_s;
   wire fibre_s;
   wire an_spd_s;
   wire an_fd_s;

   // Releases the asynchronous reset through two flip-flops.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_pipe_reg <= 2'h0;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_reg[1];

   // All pins from outside the clock domain pass two flip-flops.
   assign sync_in = {mdc_i, mdio_i, phy_addr_i, negotiation_strap_pin_i,
                     fibre_fast_mode_i, aneg_speed_100_i,
                     aneg_full_duplex_i};

   pbm_sync #(
      .W(11)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .async_i(sync_in),
      .sync_o(sync_out)
   ); // [R19]

   assign mdc_s = sync_out[10];
   assign mdio_s = sync_out[9];
   assign phy_addr_s = sync_out[8:4];
   assign strap_s = sync_out[3];
   assign fibre_s = sync_out[2];
   assign an_spd_s = sync_out[1];
   assign an_fd_s = sync_out[0];

   // -------------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------------
   reg mdc_d_reg;
   reg [2:0] state_reg;
   reg [5:0] cnt_reg;
   reg [15:0] shift_reg;
   reg [15:0] tx_reg;
   reg is_read_reg;
   reg hit_reg;
   reg [4:0] addr_reg;
   reg wr_pulse_reg;
   reg [15:0] wr_data_reg;
   reg loop_reg;
   reg speed_reg;
   reg aneg_reg;
   reg pdown_reg;
   reg duplex_reg;
   reg [15:0] adv_reg;
   reg srst_busy_reg;
   reg [7:0] srst_cnt_reg;
   wire mdc_rise;
   wire aneg_eff;
   wire [11:0] hdr;

   assign mdc_rise = mdc_s & ~mdc_d_reg;
   // Negotiation runs only when enabled, strapped on and not in fibre.
   assign aneg_eff = aneg_reg & strap_s & ~fibre_s; // [R10] [R11]
   assign hdr = {shift_reg[10:0], mdio_s};

   // -------------------------------------------------------------------
   // Read data selection
   // -------------------------------------------------------------------
   // Builds the word returned for a register address.
   function [15:0] rd_word;
      input [4:0] a;
      reg [15:0] c;
      begin
         c = 16'h0000;
         c[`PBM_CTL_LOOPBACK] = loop_reg; // [R6]
         c[`PBM_CTL_SPEED] = fibre_s | speed_reg; // [R8] [R9]
         c[`PBM_CTL_ANEG_EN] = aneg_reg & ~fibre_s; // [R13]
         c[`PBM_CTL_POWER_DOWN] = pdown_reg; // [R15]
         c[`PBM_CTL_DUPLEX] = aneg_eff ? an_fd_s : duplex_reg; // [R20]
         case (a)
            `PBM_ADDR_CONTROL: rd_word = c; // [R4]
            `PBM_ADDR_STATUS: rd_word = `PBM_RST_STATUS;
            `PBM_ADDR_ID_HIGH: rd_word = ID_HIGH; // [R17]
            `PBM_ADDR_ID_LOW: rd_word = ID_LOW; // [R17]
            `PBM_ADDR_ADVERTISE: rd_word = adv_reg;
            `PBM_ADDR_PARTNER: rd_word = `PBM_RST_PARTNER;
            `PBM_ADDR_EXPANSION: rd_word = `PBM_RST_EXPANSION;
            default: rd_word = 16'h0000;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // Management frame engine
   // -------------------------------------------------------------------
   // Samples the data line on each clock rise and drives read data
   // right after a rise, so the master sees it at the next rise.
   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mdc_d_reg <= 1'b0;
         state_reg <= S_PRE;
         cnt_reg <= 6'h00;
         shift_reg <= 16'h0000;
         tx_reg <= 16'h0000;
         is_read_reg <= 1'b0;
         hit_reg <= 1'b0;
         addr_reg <= 5'h00;
         wr_pulse_reg <= 1'b0;
         wr_data_reg <= 16'h0000;
         mdio_o <= 1'b1;
         mdio_oe_n_o <= 1'b1;
      end else begin
         mdc_d_reg <= mdc_s;
         wr_pulse_reg <= 1'b0;
         if (mdc_rise) begin
            case (state_reg)
               S_PRE: begin
                  if (mdio_s) begin
                     if (cnt_reg < PRE_BITS) begin
                        cnt_reg <= cnt_reg + 6'h01;
                     end
                  end else if (cnt_reg >= PRE_BITS) begin
                     state_reg <= S_ST;
                     cnt_reg <= 6'h00;
                  end else begin
                     cnt_reg <= 6'h00;
                  end
               end
               S_ST: begin
                  cnt_reg <= 6'h00;
                  state_reg <= mdio_s ? S_HDR : S_PRE;
               end
               S_HDR: begin
                  shift_reg <= {shift_reg[14:0], mdio_s};
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg == 6'd11) begin // [R21]
                     cnt_reg <= 6'h00;
                     is_read_reg <= (hdr[11:10] == `PBM_OP_READ);
                     hit_reg <= (hdr[9:5] == phy_addr_s);
                     addr_reg <= hdr[4:0];
                     if (hdr[11:10] == `PBM_OP_READ ||
                         hdr[11:10] == `PBM_OP_WRITE) begin
                        state_reg <= S_TA;
                     end else begin
                        state_reg <= S_PRE;
                     end
                  end
               end
               S_TA: begin
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg == 6'h00) begin
                     tx_reg <= rd_word(addr_reg);
                     if (is_read_reg && hit_reg) begin
                        mdio_o <= 1'b0;
                        mdio_oe_n_o <= 1'b0;
                     end
                  end else begin
                     state_reg <= S_DATA;
                     cnt_reg <= 6'h00;
                     mdio_o <= tx_reg[15];
                     tx_reg <= {tx_reg[14:0], 1'b0};
                  end
               end
               S_DATA: begin
                  shift_reg <= {shift_reg[14:0], mdio_s};
                  cnt_reg <= cnt_reg + 6'h01;
                  mdio_o <= tx_reg[15];
                  tx_reg <= {tx_reg[14:0], 1'b0};
                  if (cnt_reg == 6'd15) begin // [R21]
                     state_reg <= S_PRE;
                     cnt_reg <= 6'h00;
                     mdio_o <= 1'b1;
                     mdio_oe_n_o <= 1'b1;
                     wr_pulse_reg <= ~is_read_reg & hit_reg;
                     wr_data_reg <= {shift_reg[14:0], mdio_s};
                  end
               end
               default: begin
                  state_reg <= S_PRE;
                  cnt_reg <= 6'h00;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------
   // Control and advertisement registers
   // -------------------------------------------------------------------
   // Applies writes, runs the soft reset timer, and restores defaults.
   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin // [R16] [R18]
         loop_reg <= CTL_DEF[`PBM_CTL_LOOPBACK];
         speed_reg <= CTL_DEF[`PBM_CTL_SPEED];
         aneg_reg <= CTL_DEF[`PBM_CTL_ANEG_EN]; // [R12]
         pdown_reg <= CTL_DEF[`PBM_CTL_POWER_DOWN];
         duplex_reg <= CTL_DEF[`PBM_CTL_DUPLEX];
         adv_reg <= `PBM_RST_ADVERTISE;
         srst_busy_reg <= 1'b0;
         srst_cnt_reg <= 8'h00;
         aneg_restart_o <= 1'b0;
      end else begin
         aneg_restart_o <= 1'b0;
         if (srst_busy_reg) begin // [R3]
            srst_cnt_reg <= srst_cnt_reg - 8'h01;
            if (srst_cnt_reg == 8'h01) begin
               srst_busy_reg <= 1'b0; // [R2]
            end
         end else if (wr_pulse_reg &&
                      addr_reg == `PBM_ADDR_CONTROL) begin
            if (wr_data_reg[`PBM_CTL_SOFT_RESET]) begin // [R1] [R4]
               loop_reg <= CTL_DEF[`PBM_CTL_LOOPBACK];
               speed_reg <= CTL_DEF[`PBM_CTL_SPEED];
               aneg_reg <= CTL_DEF[`PBM_CTL_ANEG_EN];
               pdown_reg <= CTL_DEF[`PBM_CTL_POWER_DOWN];
               duplex_reg <= CTL_DEF[`PBM_CTL_DUPLEX];
               adv_reg <= `PBM_RST_ADVERTISE;
               srst_busy_reg <= 1'b1;
               srst_cnt_reg <= SRST_CYCLES;
            end else begin
               loop_reg <= wr_data_reg[`PBM_CTL_LOOPBACK]; // [R6]
               if (!fibre_s) begin // [R9]
                  speed_reg <= wr_data_reg[`PBM_CTL_SPEED]; // [R7]
               end
               if (strap_s && !fibre_s) begin // [R11]
                  aneg_reg <= wr_data_reg[`PBM_CTL_ANEG_EN]; // [R12]
               end
               pdown_reg <= wr_data_reg[`PBM_CTL_POWER_DOWN]; // [R15]
               if (!aneg_eff) begin // [R20]
                  duplex_reg <= wr_data_reg[`PBM_CTL_DUPLEX];
               end
               aneg_restart_o <= wr_data_reg[`PBM_CTL_ANEG_RESTART] &
                                 aneg_eff;
            end
         end else if (wr_pulse_reg &&
                      addr_reg == `PBM_ADDR_ADVERTISE) begin
            adv_reg <= wr_data_reg;
         end
      end
   end

   // -------------------------------------------------------------------
   // Mode outputs and loopback data path
   // -------------------------------------------------------------------
   // Drives the operating mode and mixes the loopback nibble.
   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rxd_o <= 4'h0;
         rx_dv_o <= 1'b0;
         loopback_o <= 1'b0;
         speed_100_o <= 1'b0;
         full_duplex_o <= 1'b0;
         aneg_enable_o <= 1'b0;
         power_down_o <= 1'b0;
         soft_reset_o <= 1'b0;
      end else begin
         rxd_o <= loop_reg ? txd_i : line_rxd_i; // [R5]
         rx_dv_o <= loop_reg ? tx_en_i : line_rx_dv_i; // [R5]
         loopback_o <= loop_reg;
         speed_100_o <= aneg_eff ? an_spd_s :
                        (fibre_s | speed_reg); // [R7] [R8] [R10]
         full_duplex_o <= aneg_eff ? an_fd_s : duplex_reg; // [R10]
         aneg_enable_o <= aneg_eff;
         power_down_o <= pdown_reg; // [R14]
         soft_reset_o <= srst_busy_reg;
      end
   end

endmodule // pbm_regs

// >>> sim/pbm_regs_checker.sv
// Port checker for the management register bank, bound to its top module.
`include "pbm_defines.vh"
module pbm_regs_checker (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire mdc_i,
   input wire mdio_i,
   input wire mdio_o,
   input wire mdio_oe_n_o,
   input wire [4:0] phy_addr_i,
   input wire negotiation_strap_pin_i,
   input wire fibre_fast_mode_i,
   input wire aneg_speed_100_i,
   input wire aneg_full_duplex_i,
   input wire [3:0] txd_i,
   input wire tx_en_i,
   input wire [3:0] line_rxd_i,
   input wire line_rx_dv_i,
   input wire [3:0] rxd_o,
   input wire rx_dv_o,
   input wire loopback_o,
   input wire speed_100_o,
   input wire full_duplex_o,
   input wire aneg_enable_o,
   input wire aneg_restart_o,
   input wire power_down_o,
   input wire soft_reset_o
);
   // ---------------------------------------------------------------
   // Helper counters
   // ---------------------------------------------------------------
   reg [8:0] srst_cnt_reg;
   reg [5:0] idle_cnt_reg;
   reg mdc_seen_reg;
   reg [3:0] rst_seen_reg;

   // Follows the design's reset release and its input synchronisers.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_seen_reg <= 4'h0;
      end else begin
         rst_seen_reg <= {rst_seen_reg[2:0], 1'b1};
      end
   end

   // Counts soft reset cycles and cycles since the last clock change.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         srst_cnt_reg <= 9'h000;
         idle_cnt_reg <= 6'h00;
         mdc_seen_reg <= 1'b0;
      end else begin
         srst_cnt_reg <= soft_reset_o ? srst_cnt_reg + 9'h001 : 9'h000;
         mdc_seen_reg <= mdc_i;
         if (mdc_i != mdc_seen_reg) idle_cnt_reg <= 6'h00;
         else if (idle_cnt_reg != 6'h3f) idle_cnt_reg <= idle_cnt_reg + 6'h01;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_seen_reg[3]);

   sequence s_loop_held;
      loopback_o ##1 loopback_o;
   endsequence
   sequence s_line_held;
      (!loopback_o && !power_down_o) [*2];
   endsequence
   sequence s_srst_run;
      soft_reset_o [*3];
   endsequence

   a_srst_length: assert property ($fell(soft_reset_o) |->
      srst_cnt_reg == `PBM_SRST_CYCLES) else $error("Soft reset length wrong");
   a_srst_defaults: assert property ($rose(soft_reset_o) |->
      ##[0:3] (!loopback_o && !power_down_o)) else $error("Defaults missing");
   a_srst_frozen: assert property (s_srst_run |->
      $stable(loopback_o) && $stable(power_down_o))
      else $error("Control changed in soft reset");
   a_loop_path: assert property (s_loop_held |->
      rxd_o == $past(txd_i) && rx_dv_o == $past(tx_en_i))
      else $error("Loopback path wrong");
   a_line_path: assert property (s_line_held |->
      rxd_o == $past(line_rxd_i) && rx_dv_o == $past(line_rx_dv_i))
      else $error("Receive path wrong");
   a_fibre_speed: assert property (fibre_fast_mode_i [*8] |=>
      speed_100_o && !aneg_enable_o) else $error("Fibre speed wrong");
   a_strap_off: assert property (
      (!negotiation_strap_pin_i || fibre_fast_mode_i) [*8] |=> !aneg_enable_o)
      else $error("Negotiation not held off");
   a_aneg_follow: assert property (
      (aneg_enable_o && aneg_speed_100_i && aneg_full_duplex_i) [*6] |=>
      speed_100_o && full_duplex_o) else $error("Negotiated mode ignored");
   a_restart_pulse: assert property (aneg_restart_o |->
      aneg_enable_o ##1 !aneg_restart_o) else $error("Restart pulse wrong");
   a_idle_release: assert property (idle_cnt_reg > 6'd30 |->
      mdio_oe_n_o && mdio_o) else $error("Data line held when idle");
endmodule // pbm_regs_checker

bind pbm_regs pbm_regs_checker i_pbm_regs_checker (.*);

// >>> sim/pbm_mac_model.sv
// Station management master model driving the management clock and data.
module pbm_mac_model (
   input wire sys_clk_i,
   input wire mdio_wire_i,
   output reg mdc_o,
   output reg mdio_o,
   output reg mdio_en_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // The clock stands still low and the line is released outside frames.
   initial begin
      mdc_o = 1'b0;
      mdio_o = 1'b1;
      mdio_en_o = 1'b0;
   end

   // One 80 ns clock period, timed by twenty system clock edges.
   task cyc(input logic en, input logic b, output logic s);
      @(posedge sys_clk_i);
      mdc_o <= 1'b0;
      mdio_o <= b;
      mdio_en_o <= en;
      repeat (10) @(posedge sys_clk_i);
      s = mdio_wire_i;
      mdc_o <= 1'b1;
      repeat (9) @(posedge sys_clk_i);
   endtask

   // Whole frame: preamble, start, op, addresses, turnaround, data.
   task frame(input logic [1:0] op, input logic [4:0] phy,
              input logic [4:0] ra, input logic [15:0] wd,
              output logic [15:0] rd);
      logic [13:0] hdr;
      logic s;
      int i;
      hdr = {2'b01, op, phy, ra};
      for (i = 0; i < 32; i++) cyc(1'b1, 1'b1, s);
      for (i = 13; i >= 0; i--) cyc(1'b1, hdr[i], s);
      cyc(op == 2'h1, 1'b1, s);
      cyc(op == 2'h1, 1'b0, s);
      for (i = 15; i >= 0; i--) begin
         cyc(op == 2'h1, wd[i], s);
         rd[i] = s;
      end
      @(posedge sys_clk_i);
      mdc_o <= 1'b0;
      mdio_en_o <= 1'b0;
      mdio_o <= 1'b1;
   endtask
endmodule // pbm_mac_model

// >>> sim/pbm_regs_bench.sv
// Self-checking bench for the management register bank.
module pbm_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [15:0] IDH = 16'h0c3c; // Arbitrary identification value.
   localparam [15:0] IDL = 16'hc3c0; // Arbitrary identification value.
   localparam [4:0] PHY = 5'h01;
   reg sys_clk_i = 1'b0;
   reg resetn_i = 1'b0;
   reg [4:0] phy_addr_i = PHY;
   reg negotiation_strap_pin_i = 1'b1;
   reg fibre_fast_mode_i = 1'b0;
   reg aneg_speed_100_i = 1'b1;
   reg aneg_full_duplex_i = 1'b1;
   reg [3:0] txd_i = 4'h0;
   reg tx_en_i = 1'b0;
   reg [3:0] line_rxd_i = 4'h0;
   reg line_rx_dv_i = 1'b0;
   wire mdc_i, mdio_i, mdio_o, mdio_oe_n_o, m_dat, m_en, rx_dv_o;
   wire [3:0] rxd_o;
   wire loopback_o, speed_100_o, full_duplex_o, aneg_enable_o;
   wire aneg_restart_o, power_down_o, soft_reset_o;
   int failures = 0;
   int check_count = 0;
   int restarts = 0;
   int srsts = 0;
   logic [15:0] rdat;

   // ---------------------------------------------------------------
   // Clock, wiring and monitors
   // ---------------------------------------------------------------
   always #2 sys_clk_i = ~sys_clk_i;
   // The line is pulled up when neither party drives it.
   assign mdio_i = !mdio_oe_n_o ? mdio_o : (m_en ? m_dat : 1'b1);
   pbm_regs #(.ID_HIGH(IDH), .ID_LOW(IDL)) i_pbm_regs (.*);
   pbm_mac_model i_pbm_mac_model (.sys_clk_i(sys_clk_i),
      .mdio_wire_i(mdio_i), .mdc_o(mdc_i), .mdio_o(m_dat), .mdio_en_o(m_en));
   // Counts restart pulses and soft reset cycles.
   always @(posedge sys_clk_i) begin
      if (aneg_restart_o === 1'b1) restarts <= restarts + 1;
      if (soft_reset_o === 1'b1) srsts <= srsts + 1;
   end

   // ---------------------------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------------------------
   task chk16(input string what, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task wr(input logic [4:0] ra, input logic [15:0] d);
      i_pbm_mac_model.frame(2'h1, PHY, ra, d, rdat);
      repeat (8) @(posedge sys_clk_i);
   endtask
   task rd(input logic [4:0] ra, input logic [15:0] e);
      i_pbm_mac_model.frame(2'h2, PHY, ra, 16'h0000, rdat);
      chk16("register read", e, rdat);
   endtask
   // Sets strap, fibre and negotiated results, then lets them settle.
   task pins(input logic strap, input logic fib, input logic spd);
      @(posedge sys_clk_i);
      negotiation_strap_pin_i <= strap;
      fibre_fast_mode_i <= fib;
      aneg_speed_100_i <= spd;
      aneg_full_duplex_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
   endtask
   // Expected order: loopback, speed, duplex, negotiation, power down.
   task outs(input logic [4:0] e);
      chk16("control outputs", {11'h000, e}, {11'h000, loopback_o,
         speed_100_o, full_duplex_o, aneg_enable_o, power_down_o});
   endtask
   task complete_run;
      $display("Checks made %0d, failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      rd(5'h00, 16'h3100);
      rd(5'h01, 16'h7849);
      rd(5'h02, IDH);
      rd(5'h03, IDL);
      rd(5'h04, 16'h01e1);
      rd(5'h05, 16'h0080);
      rd(5'h06, 16'h0000);
      rd(5'h07, 16'h0000);
      outs(5'b01110);
      wr(5'h01, 16'hffff);
      rd(5'h01, 16'h7849);
      wr(5'h04, 16'h05e1);
      rd(5'h04, 16'h05e1);
      // Forced speed and duplex, then negotiation back on.
      pins(1'b1, 1'b0, 1'b1);
      wr(5'h00, 16'h0100);
      outs(5'b00100);
      rd(5'h00, 16'h0100);
      wr(5'h00, 16'h2000);
      outs(5'b01000);
      rd(5'h00, 16'h2000);
      wr(5'h00, 16'h1000);
      outs(5'b01010);
      rd(5'h00, 16'h1000);
      wr(5'h00, 16'h1200);
      chk16("restart pulses", 16'h0001, restarts[15:0]);
      // Loopback of the transmit nibble.
      @(posedge sys_clk_i);
      txd_i <= 4'ha;
      tx_en_i <= 1'b1;
      line_rxd_i <= 4'h5;
      wr(5'h00, 16'h5000);
      chk16("loop receive", 16'h001a, {11'h000, rx_dv_o, rxd_o});
      rd(5'h00, 16'h5000);
      wr(5'h00, 16'h1000);
      chk16("line receive", 16'h0005, {11'h000, rx_dv_o, rxd_o});
      // Power down keeps the management path alive.
      wr(5'h00, 16'h1800);
      outs(5'b01011);
      rd(5'h00, 16'h1800);
      wr(5'h00, 16'h1000);
      outs(5'b01010);
      // Soft reset from a changed state.
      wr(5'h00, 16'h4900);
      wr(5'h00, 16'h8000);
      repeat (260) @(posedge sys_clk_i);
      chk16("soft reset cycles", 16'd250, srsts[15:0]);
      outs(5'b01010);
      rd(5'h00, 16'h3000);
      rd(5'h04, 16'h01e1);
      // Strap and fibre mode override the register.
      pins(1'b0, 1'b0, 1'b1);
      wr(5'h00, 16'h0000);
      outs(5'b00000);
      rd(5'h00, 16'h1000);
      pins(1'b1, 1'b1, 1'b1);
      wr(5'h00, 16'h0000);
      outs(5'b01000);
      rd(5'h00, 16'h2000);
      pins(1'b1, 1'b0, 1'b1);
      // Chip reset in mid-run restores loopback, negotiation and power.
      wr(5'h00, 16'h4800);
      outs(5'b10001);
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      outs(5'b01010);
      rd(5'h00, 16'h3000);
      // An unknown operation code drops the frame.
      i_pbm_mac_model.frame(2'h3, PHY, 5'h04, 16'h0000, rdat);
      rd(5'h04, 16'h01e1);
      // Frames for another device address are not answered.
      i_pbm_mac_model.frame(2'h1, 5'h1e, 5'h00, 16'h4000, rdat);
      i_pbm_mac_model.frame(2'h2, 5'h1e, 5'h00, 16'h0000, rdat);
      chk16("foreign read", 16'hffff, rdat);
      outs(5'b01010);
      complete_run;
   end

   // Cuts a hung run short.
   initial begin
      repeat (90000) @(posedge sys_clk_i);
      failures++;
      complete_run;
   end
endmodule // pbm_regs_bench
